// *** rsm_consts.svh ***
`ifndef RSM_CONSTS_SVH
`define RSM_CONSTS_SVH
// What this block does
// (R1) Mode C strap low full, high host
// (R2) Operating mode fixed until next reset
// (R3) Full mode: 14-bit address, 24-bit data
// (R4) Byte access: high address on D23:16
// (R5) Host mode: address/data port, A0, D23:8
// (R6) Host drives strobes; ack open drain; code drives ack push-pull when Mode D strap is low
// (R7) Host decodes A0 with memory selects
// (R8) Straps read in reset, then flags
// (R9) Shared pins: interrupt and flag together
// (R10) Masked pin asserted sets interrupt, any driver
// (R11) Control bit: serial port or irq/flags
// (R12) Serial role changes anytime, bus fixed
// (R13) Straps latched at reset release edge

// Pin group widths
`define RSM_ADDR_W 14
`define RSM_DATA_W 24
`define RSM_HOST_W 16
`define RSM_BYTE_HI_W 8
`define RSM_PF_W 8
`define RSM_SP_W 5
`define RSM_IRQ_N 6

// Register index on the 4-bit address
`define RSM_REG_SYSCTL 4'h0
`define RSM_REG_FLAG_DIR 4'h1
`define RSM_REG_FLAG_OUT 4'h2
`define RSM_REG_FLAG_IN 4'h3
`define RSM_REG_IRQ_MASK 4'h4
`define RSM_REG_IRQ_STAT 4'h5
`define RSM_REG_MODE 4'h6

// Strap bit positions in the latched strap
`define RSM_STRAP_HOST_BIT 2
`define RSM_STRAP_ACK_BIT 3

// Data pin roles in host mode
`define RSM_DP_WR 7
`define RSM_DP_RD 6
`define RSM_DP_AL 5
`define RSM_DP_SEL 4
`define RSM_DP_ACK 3

// Second serial port pin positions
`define RSM_SP_SCLK 0
`define RSM_SP_RFS 1
`define RSM_SP_DR 2
`define RSM_SP_TFS 3
`define RSM_SP_DT 4

// Reset values
`define RSM_SYSCTL_RST 1'b0
`define RSM_FDIR_RST 8'h00
`define RSM_FOUT_RST 9'h1ff
`define RSM_MASK_RST 6'h00
`endif

// *** rsm_pkg.sv ***
`include "rsm_consts.svh"
package rsm_pkg;

  typedef enum logic {
    RSM_PH_RESET = 1'b0,
    RSM_PH_RUN = 1'b1
  } rsm_phase_t;

  // Core side of the external bus
  typedef struct packed {
    logic [`RSM_ADDR_W-1:0] addr;
    logic addr_oe;
    logic [`RSM_DATA_W-1:0] data_out;
    logic data_oe;
    logic byte_acc;
    logic [`RSM_BYTE_HI_W-1:0] byte_hi;
  } rsm_core_bus_t;

  // Host port engine drive toward the pins
  typedef struct packed {
    logic [`RSM_HOST_W-1:0] ad_out;
    logic ad_oe;
    logic ack_n;
  } rsm_host_drv_t;

  // Host strobes and address/data seen on the pins
  typedef struct packed {
    logic [`RSM_HOST_W-1:0] ad_in;
    logic wr_en_n;
    logic rd_en_n;
    logic addr_latch;
    logic select_n;
  } rsm_host_t;

  typedef struct packed {
    logic [`RSM_IRQ_N-1:0] prev_n;
    logic [`RSM_IRQ_N-1:0] status;
    logic irq;
  } rsm_irq_state_t;

  typedef struct packed {
    rsm_phase_t phase;
    logic [3:0] strap;
    logic sysctl;
    logic [`RSM_PF_W-1:0] fdir;
    logic [`RSM_PF_W:0] fout;
    logic [`RSM_IRQ_N-1:0] mask;
    logic [15:0] rdata;
    logic [`RSM_ADDR_W-1:0] ap_o;
    logic [`RSM_ADDR_W-1:0] ap_oe;
    logic [`RSM_DATA_W-1:0] dp_o;
    logic [`RSM_DATA_W-1:0] dp_oe;
    logic [`RSM_PF_W-1:0] pf_o;
    logic [`RSM_PF_W-1:0] pf_oe;
    logic [`RSM_SP_W-1:0] sp_o;
    logic [`RSM_SP_W-1:0] sp_oe;
    logic [`RSM_SP_W-1:0] sp_in;
    logic [`RSM_DATA_W-1:0] data_in;
    rsm_host_t host;
  } rsm_state_t;

endpackage : rsm_pkg

// *** rsm_irq_status.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "rsm_consts.svh"
module rsm_irq_status (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [`RSM_IRQ_N-1:0] i_req_n,
  input wire logic i_clear,
  input wire logic [`RSM_IRQ_N-1:0] i_mask,
  output logic [`RSM_IRQ_N-1:0] o_status,
  output logic o_irq
);

  rsm_pkg::rsm_irq_state_t s_r;
  rsm_pkg::rsm_irq_state_t s_nxt;

  // Sticky on the assertion edge; a set in the clearing read cycle survives
  always_comb begin
    s_nxt = s_r;
    s_nxt.prev_n = i_req_n;
    for (int i = 0; i < `RSM_IRQ_N; i++) begin
      if (i_clear) begin
        s_nxt.status[i] = 1'b0;
      end
      if (s_r.prev_n[i] && !i_req_n[i]) begin
        s_nxt.status[i] = 1'b1; // see (R10)
      end
    end
    s_nxt.irq = |(s_nxt.status & i_mask); // see (R10)
    if (!i_rst_n) begin
      s_nxt.prev_n = '1;
      s_nxt.status = '0;
      s_nxt.irq = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    s_r <= s_nxt;
  end

  assign o_status = s_r.status;
  assign o_irq = s_r.irq;

endmodule : rsm_irq_status
`default_nettype wire

// *** rsm_pin_mux.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "rsm_consts.svh"
module rsm_pin_mux #(
  parameter int ADDR_W = `RSM_ADDR_W,
  parameter int DATA_W = `RSM_DATA_W
) (
  input wire logic i_clk,
  input wire logic i_rst_n,

  // Register port
  input wire logic [3:0] i_reg_addr,
  input wire logic [15:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [15:0] o_reg_rdata,

  // Core and host engine side
  input wire rsm_pkg::rsm_core_bus_t i_core,
  output logic [`RSM_DATA_W-1:0] o_core_data_in,
  input wire rsm_pkg::rsm_host_drv_t i_host_drv,
  output rsm_pkg::rsm_host_t o_host,
  input wire logic [`RSM_SP_W-1:0] i_sp_out,
  input wire logic [`RSM_SP_W-1:0] i_sp_oe,
  output logic [`RSM_SP_W-1:0] o_sp_in,

  // Address pins
  input wire logic [`RSM_ADDR_W-1:0] i_ap,
  output logic [`RSM_ADDR_W-1:0] o_ap,
  output logic [`RSM_ADDR_W-1:0] o_ap_oe,

  // Data pins
  input wire logic [`RSM_DATA_W-1:0] i_dp,
  output logic [`RSM_DATA_W-1:0] o_dp,
  output logic [`RSM_DATA_W-1:0] o_dp_oe,

  // Flag pins, low four double as mode straps
  input wire logic [`RSM_PF_W-1:0] i_pf,
  output logic [`RSM_PF_W-1:0] o_pf,
  output logic [`RSM_PF_W-1:0] o_pf_oe,

  // Second serial port pins
  input wire logic [`RSM_SP_W-1:0] i_sp,
  output logic [`RSM_SP_W-1:0] o_sp,
  output logic [`RSM_SP_W-1:0] o_sp_oe,

  // Status toward the core
  output logic o_host_mode,
  output logic [3:0] o_strap,
  output logic o_irq
);

  // Pin mapping below is fixed to the documented bus widths
  if (ADDR_W != `RSM_ADDR_W || DATA_W != `RSM_DATA_W) begin : g_bad_width
    $error("rsm_pin_mux: address and data widths are fixed");
  end

  rsm_pkg::rsm_state_t s_r;
  rsm_pkg::rsm_state_t s_nxt;

  logic host_mode;
  logic ack_od;
  logic sp_flags;
  logic [`RSM_IRQ_N-1:0] irq_req_n;
  logic [`RSM_IRQ_N-1:0] irq_status;
  logic stat_clear;

  // Mode comes only from the latched straps, never the live pins
  assign host_mode = s_r.strap[`RSM_STRAP_HOST_BIT]; // see (R13)
  assign ack_od = s_r.strap[`RSM_STRAP_ACK_BIT];
  assign sp_flags = s_r.sysctl;

  // Flag pins 7:4 feed interrupts straight from the pad level, so a pin the
  // block drives as an output asserts its interrupt just like an external one
  always_comb begin
    irq_req_n = '1;
    irq_req_n[3:0] = i_pf[7:4]; // see (R9) see (R10)
    // Wait until the engine has let go of the pins, else its last low level reads as an edge
    if (sp_flags && s_r.phase == rsm_pkg::RSM_PH_RUN && !s_r.sp_oe[`RSM_SP_RFS]) begin
      irq_req_n[4] = i_sp[`RSM_SP_RFS]; // see (R11)
      irq_req_n[5] = i_sp[`RSM_SP_TFS];
    end
    if (s_r.phase == rsm_pkg::RSM_PH_RESET) begin
      irq_req_n = '1;
    end
  end

  assign stat_clear = i_reg_rd && (i_reg_addr == `RSM_REG_IRQ_STAT);

  rsm_irq_status u_irq (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_req_n(irq_req_n),
    .i_clear(stat_clear),
    .i_mask(s_r.mask),
    .o_status(irq_status),
    .o_irq(o_irq)
  );

  // Next state of the whole block
  always_comb begin
    s_nxt = s_r;

    // Straps captured once, on the first edge after reset lets go
    if (s_r.phase == rsm_pkg::RSM_PH_RESET) begin
      s_nxt.phase = rsm_pkg::RSM_PH_RUN;
      s_nxt.strap = i_pf[3:0]; // see (R1) see (R8) see (R13)
    end

    // Register writes; the strap latch has no write path
    if (i_reg_wr) begin // see (R2)
      unique case (i_reg_addr)
        `RSM_REG_SYSCTL: begin
          s_nxt.sysctl = i_reg_wdata[0]; // see (R11) see (R12)
        end
        `RSM_REG_FLAG_DIR: begin
          s_nxt.fdir = i_reg_wdata[`RSM_PF_W-1:0];
        end
        `RSM_REG_FLAG_OUT: begin
          s_nxt.fout = i_reg_wdata[`RSM_PF_W:0];
        end
        `RSM_REG_IRQ_MASK: begin
          s_nxt.mask = i_reg_wdata[`RSM_IRQ_N-1:0];
        end
        default: begin
        end
      endcase
    end

    // Read data stands only in the cycle after the strobe
    s_nxt.rdata = 16'h0000;
    if (i_reg_rd) begin
      unique case (i_reg_addr)
        `RSM_REG_SYSCTL: begin
          s_nxt.rdata = {15'h0000, s_r.sysctl};
        end
        `RSM_REG_FLAG_DIR: begin
          s_nxt.rdata = {8'h00, s_r.fdir};
        end
        `RSM_REG_FLAG_OUT: begin
          s_nxt.rdata = {7'h00, s_r.fout};
        end
        `RSM_REG_FLAG_IN: begin
          s_nxt.rdata = {7'h00, i_sp[`RSM_SP_DR], i_pf};
        end
        `RSM_REG_IRQ_MASK: begin
          s_nxt.rdata = {10'h000, s_r.mask};
        end
        `RSM_REG_IRQ_STAT: begin
          s_nxt.rdata = {10'h000, irq_status};
        end
        `RSM_REG_MODE: begin
          s_nxt.rdata = {11'h000, host_mode, s_r.strap};
        end
        default: begin
          s_nxt.rdata = 16'h0000;
        end
      endcase
    end

    // Flag pins: released from strap duty, driven per direction bit
    s_nxt.pf_o = s_r.fout[`RSM_PF_W-1:0]; // see (R8) see (R9)
    s_nxt.pf_oe = s_r.fdir;

    // Second serial port; sclk keeps its serial role in both settings
    s_nxt.sp_o = i_sp_out;
    s_nxt.sp_oe = i_sp_oe;
    s_nxt.sp_in = i_sp;
    if (sp_flags) begin // see (R11) see (R12)
      s_nxt.sp_o[`RSM_SP_DT] = s_r.fout[`RSM_PF_W];
      s_nxt.sp_oe[`RSM_SP_DT] = 1'b1;
      s_nxt.sp_oe[`RSM_SP_RFS] = 1'b0;
      s_nxt.sp_oe[`RSM_SP_TFS] = 1'b0;
      s_nxt.sp_oe[`RSM_SP_DR] = 1'b0;
      s_nxt.sp_in[`RSM_SP_RFS] = 1'b0;
      s_nxt.sp_in[`RSM_SP_TFS] = 1'b0;
      s_nxt.sp_in[`RSM_SP_DR] = 1'b0;
    end

    if (!host_mode) begin
      // Full memory mode: whole address and data bus
      s_nxt.ap_o = i_core.addr; // see (R3)
      s_nxt.ap_oe = {`RSM_ADDR_W{i_core.addr_oe}};
      s_nxt.dp_o = i_core.data_out;
      s_nxt.dp_oe = {`RSM_DATA_W{i_core.data_oe}};
      s_nxt.data_in = i_dp;
      if (i_core.byte_acc) begin
        // Upper data lines carry the high byte memory address
        s_nxt.dp_o[23:16] = i_core.byte_hi; // see (R4)
        s_nxt.dp_oe[23:16] = 8'hff;
      end
      // Host strobes held inactive outside host mode
      s_nxt.host.ad_in = 16'h0000;
      s_nxt.host.wr_en_n = 1'b1;
      s_nxt.host.rd_en_n = 1'b1;
      s_nxt.host.addr_latch = 1'b0;
      s_nxt.host.select_n = 1'b1;
    end else begin
      // Host mode: A0 stays an address output
      s_nxt.ap_o[0] = i_core.addr[0]; // see (R5) see (R7)
      s_nxt.ap_oe[0] = i_core.addr_oe;
      // A13:1 become host address/data 12:0
      s_nxt.ap_o[13:1] = i_host_drv.ad_out[12:0]; // see (R5)
      s_nxt.ap_oe[13:1] = {13{i_host_drv.ad_oe}};
      // D23:8 remain the 16-bit external data bus
      s_nxt.dp_o[23:8] = i_core.data_out[23:8];
      s_nxt.dp_oe[23:8] = {16{i_core.data_oe}};
      s_nxt.data_in = {i_dp[23:8], 8'h00};
      // D7:4 are host strobes, inputs only
      s_nxt.dp_o[7:4] = 4'h0; // see (R6)
      s_nxt.dp_oe[7:4] = 4'h0;
      // D2:0 become host address/data 15:13
      s_nxt.dp_o[2:0] = i_host_drv.ad_out[15:13];
      s_nxt.dp_oe[2:0] = {3{i_host_drv.ad_oe}};
      // Acknowledge: open drain pulls low only, else push-pull
      if (ack_od) begin // see (R6)
        s_nxt.dp_o[`RSM_DP_ACK] = 1'b0;
        s_nxt.dp_oe[`RSM_DP_ACK] = !i_host_drv.ack_n;
      end else begin
        s_nxt.dp_o[`RSM_DP_ACK] = i_host_drv.ack_n;
        s_nxt.dp_oe[`RSM_DP_ACK] = 1'b1;
      end
      s_nxt.host.ad_in = {i_dp[2:0], i_ap[13:1]};
      s_nxt.host.wr_en_n = i_dp[`RSM_DP_WR];
      s_nxt.host.rd_en_n = i_dp[`RSM_DP_RD];
      s_nxt.host.addr_latch = i_dp[`RSM_DP_AL];
      s_nxt.host.select_n = i_dp[`RSM_DP_SEL];
    end

    // Capture cycle drives nothing: straps just latched, mode not yet in use
    if (s_r.phase == rsm_pkg::RSM_PH_RESET) begin
      s_nxt.ap_oe = '0;
      s_nxt.dp_oe = '0;
      s_nxt.pf_oe = '0;
      s_nxt.sp_oe = '0;
    end

    // Synchronous reset: all pins float so straps can be read
    if (!i_rst_n) begin
      s_nxt.phase = rsm_pkg::RSM_PH_RESET;
      s_nxt.strap = 4'h0;
      s_nxt.sysctl = `RSM_SYSCTL_RST;
      s_nxt.fdir = `RSM_FDIR_RST;
      s_nxt.fout = `RSM_FOUT_RST;
      s_nxt.mask = `RSM_MASK_RST;
      s_nxt.rdata = 16'h0000;
      s_nxt.ap_o = '0;
      s_nxt.ap_oe = '0;
      s_nxt.dp_o = '0;
      s_nxt.dp_oe = '0;
      s_nxt.pf_o = '0;
      s_nxt.pf_oe = '0; // see (R8)
      s_nxt.sp_o = '0;
      s_nxt.sp_oe = '0;
      s_nxt.sp_in = '0;
      s_nxt.data_in = '0;
      s_nxt.host.ad_in = 16'h0000;
      s_nxt.host.wr_en_n = 1'b1;
      s_nxt.host.rd_en_n = 1'b1;
      s_nxt.host.addr_latch = 1'b0;
      s_nxt.host.select_n = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    s_r <= s_nxt;
  end

  // All outputs but o_irq come straight from the state register; o_irq comes from the register in u_irq
  assign o_reg_rdata = s_r.rdata;
  assign o_core_data_in = s_r.data_in;
  assign o_host = s_r.host;
  assign o_sp_in = s_r.sp_in;
  assign o_ap = s_r.ap_o;
  assign o_ap_oe = s_r.ap_oe;
  assign o_dp = s_r.dp_o;
  assign o_dp_oe = s_r.dp_oe;
  assign o_pf = s_r.pf_o;
  assign o_pf_oe = s_r.pf_oe;
  assign o_sp = s_r.sp_o;
  assign o_sp_oe = s_r.sp_oe;
  assign o_host_mode = host_mode;
  assign o_strap = s_r.strap;

endmodule : rsm_pin_mux
`default_nettype wire

// *** rsm_pin_mux_sva.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "rsm_consts.svh"
module rsm_pin_mux_sva (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire rsm_pkg::rsm_core_bus_t i_core,
  input wire rsm_pkg::rsm_host_drv_t i_host_drv,
  input wire logic [`RSM_DATA_W-1:0] i_dp,
  input wire logic [`RSM_PF_W-1:0] i_pf,
  input wire rsm_pkg::rsm_host_t o_host,
  input wire logic [`RSM_ADDR_W-1:0] o_ap,
  input wire logic [`RSM_ADDR_W-1:0] o_ap_oe,
  input wire logic [`RSM_DATA_W-1:0] o_dp,
  input wire logic [`RSM_DATA_W-1:0] o_dp_oe,
  input wire logic [`RSM_PF_W-1:0] o_pf_oe,
  input wire logic o_host_mode,
  input wire logic [3:0] o_strap
);
  logic [1:0] run_cnt_r;
  logic run;
  // Pins follow the mode only from the second edge after release, as they float one extra cycle
  always_ff @(posedge i_clk) begin
    if (!i_rst_n)
      run_cnt_r <= 2'h0;
    else if (run_cnt_r != 2'h2)
      run_cnt_r <= run_cnt_r + 2'h1;
  end
  assign run = (run_cnt_r == 2'h2);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_release;
    $rose(i_rst_n);
  endsequence
  sequence s_float2;
    (o_ap_oe == '0 && o_dp_oe == '0 && o_pf_oe == '0) [*2];
  endsequence
  AST_FLOAT_AT_RELEASE: assert property (s_release |-> s_float2)
    else $error("pins driven around reset release");
  AST_STRAP_CAPTURE: assert property (s_release |=>
    o_strap == $past(i_pf[3:0]) && o_host_mode == $past(i_pf[2]))
    else $error("straps not captured at release edge");
  AST_MODE_HELD: assert property ($past(i_rst_n) && $past(i_rst_n, 2) |->
    $stable(o_host_mode) && $stable(o_strap))
    else $error("mode changed while running");
  AST_FULL_ADDR: assert property (run && !o_host_mode |->
    o_ap == $past(i_core.addr) && o_ap_oe == {14{$past(i_core.addr_oe)}})
    else $error("full mode address pins wrong");
  AST_FULL_DATA: assert property (run && !o_host_mode && !$past(i_core.byte_acc) |->
    o_dp == $past(i_core.data_out) && o_dp_oe == {24{$past(i_core.data_oe)}})
    else $error("full mode data pins wrong");
  AST_BYTE_HI: assert property (run && !o_host_mode && $past(i_core.byte_acc) |->
    o_dp[23:16] == $past(i_core.byte_hi) && o_dp_oe[23:16] == 8'hff)
    else $error("byte address bits missing");
  AST_HOST_OE: assert property (run && o_host_mode |->
    o_ap_oe[13:1] == {13{$past(i_host_drv.ad_oe)}} && o_dp_oe[7:4] == 4'h0)
    else $error("host port enables wrong");
  AST_HOST_AD: assert property (run && o_host_mode && $past(i_host_drv.ad_oe) |->
    {o_dp[2:0], o_ap[13:1]} == $past(i_host_drv.ad_out) && o_ap[0] == $past(i_core.addr[0]))
    else $error("host address/data out wrong");
  AST_HOST_STROBES: assert property (run && o_host_mode |->
    {o_host.wr_en_n, o_host.rd_en_n, o_host.addr_latch, o_host.select_n} == $past(i_dp[7:4]))
    else $error("host strobes not passed in");
  AST_ACK_OD: assert property (run && o_host_mode && o_strap[3] |->
    o_dp[3] == 1'b0 && o_dp_oe[3] == !$past(i_host_drv.ack_n))
    else $error("open drain acknowledge wrong");
  AST_ACK_PP: assert property (run && o_host_mode && !o_strap[3] |->
    o_dp[3] == $past(i_host_drv.ack_n) && o_dp_oe[3] == 1'b1)
    else $error("push-pull acknowledge wrong");
endmodule : rsm_pin_mux_sva
`default_nettype wire

// *** rsm_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module rsm_host_model (
  input wire logic i_on,
  input wire logic [3:0] i_strb,
  input wire logic [15:0] i_ad,
  input wire logic i_ad_en,
  output logic [23:0] o_dp,
  output logic [23:0] o_dp_en,
  output logic [13:0] o_ap,
  output logic [13:0] o_ap_en
);
  // Host owns the strobe lines; it drives address/data only while i_ad_en is high
  assign o_dp = {16'h0000, i_strb, 1'b0, i_ad[15:13]};
  assign o_dp_en = {16'h0000, {4{i_on}}, 1'b0, {3{i_ad_en}}};
  assign o_ap = {i_ad[12:0], 1'b0};
  assign o_ap_en = {{13{i_ad_en}}, 1'b0};
endmodule : rsm_host_model
`default_nettype wire

// *** rsm_pin_mux_test.sv ***
`timescale 1ns/10ps
`default_nettype none
module rsm_pin_mux_test;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [3:0] ra = 4'h0;
  logic [15:0] rw = 16'h0000;
  logic wr = 1'b0, rd = 1'b0, h_on = 1'b0, h_ad_en = 1'b0, hmode, irq;
  logic [15:0] rdat, h_ad = 16'h0000;
  rsm_pkg::rsm_core_bus_t core = '0;
  rsm_pkg::rsm_host_drv_t hdrv = '0;
  rsm_pkg::rsm_host_t host;
  logic [4:0] spo = 5'h00, spoe = 5'h1f, sp_v = 5'h1f, sp, o_sp, o_sp_oe, spin;
  logic [13:0] ap, o_ap, o_ap_oe, h_ap, h_ap_en;
  logic [23:0] dp, o_dp, o_dp_oe, h_dp, h_dp_en, cdin;
  logic [7:0] pf, o_pf, o_pf_oe, pf_v = 8'h00, pf_en = 8'h0f;
  logic [3:0] strb = 4'hd, strap;
  int n_mismatch = 0, samples_checked = 0;
  // Undriven lines sit at the board pull-up level
  assign dp = (o_dp_oe & o_dp) | (~o_dp_oe & h_dp_en & h_dp) | (~o_dp_oe & ~h_dp_en);
  assign ap = (o_ap_oe & o_ap) | (~o_ap_oe & h_ap_en & h_ap) | (~o_ap_oe & ~h_ap_en);
  assign pf = (o_pf_oe & o_pf) | (~o_pf_oe & pf_en & pf_v) | (~o_pf_oe & ~pf_en);
  assign sp = (o_sp_oe & o_sp) | (~o_sp_oe & sp_v);
  always #20 i_clk = ~i_clk;
  rsm_pin_mux rsm_pin_mux_i (.i_clk, .i_rst_n, .i_reg_addr(ra), .i_reg_wdata(rw),
    .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdat), .i_core(core), .o_core_data_in(cdin),
    .i_host_drv(hdrv), .o_host(host), .i_sp_out(spo), .i_sp_oe(spoe), .o_sp_in(spin),
    .i_ap(ap), .o_ap, .o_ap_oe, .i_dp(dp), .o_dp, .o_dp_oe, .i_pf(pf), .o_pf, .o_pf_oe,
    .i_sp(sp), .o_sp, .o_sp_oe, .o_host_mode(hmode), .o_strap(strap), .o_irq(irq));
  rsm_host_model rsm_host_model_i (.i_on(h_on), .i_strb(strb), .i_ad(h_ad),
    .i_ad_en(h_ad_en), .o_dp(h_dp), .o_dp_en(h_dp_en), .o_ap(h_ap), .o_ap_en(h_ap_en));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : step
  // One-cycle strobes, driven right after the edge
  task automatic wreg(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_clk);
    ra <= a;
    rw <= d;
    wr <= 1'b1;
    @(posedge i_clk);
    wr <= 1'b0;
  endtask : wreg
  task automatic rchk(input logic [3:0] a, input logic [15:0] e);
    @(posedge i_clk);
    ra <= a;
    rd <= 1'b1;
    @(posedge i_clk);
    rd <= 1'b0;
    #1;
    chk(rdat, e);
  endtask : rchk
  task automatic do_reset(input logic [7:0] s);
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    pf_en <= 8'h0f;
    pf_v <= s;
    repeat (6) @(posedge i_clk);
    i_rst_n <= 1'b1;
    step(3);
  endtask : do_reset
  task automatic complete_run;
    $display("checks=%0d mismatches=%0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  // Main sequence: full mode, shared pins, serial role, then host mode
  initial begin
    do_reset(8'h00);
    rchk(4'h6, 16'h0000);
    @(posedge i_clk);
    pf_en <= 8'h04;
    pf_v <= 8'h04;
    core <= '{14'h2a5a, 1'b1, 24'h123456, 1'b1, 1'b0, 8'ha7};
    step(2);
    chk(hmode, 1'b0);
    chk({o_ap, o_ap_oe}, {14'h2a5a, 14'h3fff});
    chk(o_dp, 24'h123456);
    @(posedge i_clk);
    core.byte_acc <= 1'b1;
    step(2);
    chk({o_dp_oe[23:16], o_dp}, 32'hffa73456);
    chk(cdin, 24'ha73456);
    rchk(4'h6, 16'h0000);
    rchk(4'ha, 16'h0000);
    wreg(4'h4, 16'h0012);
    @(posedge i_clk);
    pf_en <= 8'h20;
    pf_v <= 8'h00;
    step(4);
    chk(irq, 1'b1);
    rchk(4'h5, 16'h0002);
    step(2);
    chk(irq, 1'b0);
    @(posedge i_clk);
    pf_en <= 8'h00;
    step(2);
    wreg(4'h1, 16'h002f);
    wreg(4'h2, 16'h01d5);
    step(4);
    chk({o_pf_oe, o_pf[3:0]}, 12'h2f5);
    chk(irq, 1'b1);
    rchk(4'h3, 16'h00d5);
    rchk(4'h5, 16'h0002);
    wreg(4'h0, 16'h0001);
    step(3);
    chk({o_sp_oe, o_sp[4]}, 6'h23);
    @(posedge i_clk);
    sp_v <= 5'h1d;
    step(4);
    chk(spin, 5'h10);
    chk(irq, 1'b1);
    rchk(4'h5, 16'h0010);
    wreg(4'h0, 16'h0000);
    step(3);
    chk({o_sp_oe, o_sp}, 10'h3e0);
    chk(spin, 5'h00);
    do_reset(8'h0c);
    rchk(4'h6, 16'h001c);
    @(posedge i_clk);
    h_on <= 1'b1;
    strb <= 4'h5;
    hdrv <= '{16'hbeef, 1'b1, 1'b0};
    step(3);
    chk({o_dp[2:0], o_ap}, {16'hbeef, 1'b0});
    chk({o_dp_oe[3], o_dp[3]}, 2'b10);
    chk({host.wr_en_n, host.rd_en_n, host.addr_latch, host.select_n}, 4'h5);
    chk(cdin, 24'h123400);
    @(posedge i_clk);
    hdrv <= '{16'hbeef, 1'b0, 1'b1};
    h_ad_en <= 1'b1;
    h_ad <= 16'h1234;
    step(3);
    chk(host.ad_in, 16'h1234);
    chk({o_dp_oe[3], o_dp[3]}, 2'b00);
    // Mode D low: acknowledge becomes push-pull
    do_reset(8'h04);
    rchk(4'h6, 16'h0014);
    chk({o_dp_oe[3], o_dp[3]}, 2'b11);
    complete_run();
  end
  // Watchdog well beyond the hundred or so cycles the tests need
  initial begin
    repeat (2000) @(posedge i_clk);
    n_mismatch++;
    complete_run();
  end
endmodule : rsm_pin_mux_test
bind rsm_pin_mux rsm_pin_mux_sva rsm_pin_mux_sva_i (.i_clk, .i_rst_n, .i_core, .i_host_drv,
  .i_dp, .i_pf, .o_host, .o_ap, .o_ap_oe, .o_dp, .o_dp_oe, .o_pf_oe, .o_host_mode, .o_strap);
`default_nettype wire
